//--- design/tmc_pkg.sv
// Constants shared by the timer clock and gate control block.
package tmc_pkg;
    localparam int unsigned ADDR_W        = 2;
    localparam int unsigned DATA_W        = 8;
    localparam int unsigned CNT_W         = 16;
    localparam int unsigned PRE_W         = 3;

    localparam logic [1:0] ADDR_CONTROL   = 2'h0;
    localparam logic [1:0] ADDR_GATE      = 2'h1;
    localparam logic [1:0] ADDR_COUNT_LO  = 2'h2;
    localparam logic [1:0] ADDR_COUNT_HI  = 2'h3;

    localparam int unsigned CTL_CS_HI     = 7;
    localparam int unsigned CTL_CS_LO     = 6;
    localparam int unsigned CTL_PS_HI     = 5;
    localparam int unsigned CTL_PS_LO     = 4;
    localparam int unsigned CTL_OSCEN     = 3;
    localparam int unsigned CTL_NOSYNC    = 2;
    localparam int unsigned CTL_RUN       = 0;
    localparam logic [7:0]  CTL_WMASK     = 8'hfd;
    localparam logic [7:0]  CTL_RESET     = 8'h00;

    localparam int unsigned GT_EN         = 7;
    localparam int unsigned GT_POL        = 6;
    localparam int unsigned GT_TM         = 5;
    localparam int unsigned GT_SPM        = 4;
    localparam int unsigned GT_GO         = 3;
    localparam int unsigned GT_VAL        = 2;
    localparam int unsigned GT_SS_HI      = 1;
    localparam int unsigned GT_SS_LO      = 0;
    localparam logic [7:0]  GT_WMASK      = 8'hf3;
    localparam logic [7:0]  GT_RESET      = 8'h00;

    localparam logic [1:0] CS_INSTR       = 2'h0;
    localparam logic [1:0] CS_SYSTEM      = 2'h1;
    localparam logic [1:0] CS_EXTERNAL    = 2'h2;
    localparam logic [1:0] CS_CAP_OSC     = 2'h3;

    localparam logic [1:0] GS_PIN         = 2'h0;
    localparam logic [1:0] GS_OTHER_TMR   = 2'h1;
    localparam logic [1:0] GS_COMP1       = 2'h2;
    localparam logic [1:0] GS_COMP2       = 2'h3;

    localparam logic [1:0] INSTR_DIV_LAST = 2'h3;
    localparam logic [PRE_W-1:0] PRE_ZERO = 3'h0;
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE  = 16'h0001;
    localparam logic [CNT_W-1:0] CNT_MAX  = 16'hffff;
    localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
endpackage : tmc_pkg

//--- design/tmc_prescaler.sv
// Input prescaler that passes one of every 1, 2, 4 or 8 source ticks.
`timescale 1ns/1ps
module tmc_prescaler (
    input  wire logic       sys_clk,
    input  wire logic       resetn,
    input  wire logic       tick,
    input  wire logic [1:0] select,
    input  wire logic       hold_clear,
    output logic            pulse
);
    logic [tmc_pkg::PRE_W-1:0] count;
    logic [tmc_pkg::PRE_W-1:0] next_count;
    logic [tmc_pkg::PRE_W-1:0] last;

    // Last count value before a pulse: 0, 1, 3 or 7.
    function automatic logic [tmc_pkg::PRE_W-1:0] last_count(input logic [1:0] sel);
        case (sel)
            2'h0:    last_count = 3'h0;
            2'h1:    last_count = 3'h1;
            2'h2:    last_count = 3'h3;
            default: last_count = 3'h7;
        endcase
    endfunction : last_count

    always_comb begin
        last = last_count(select);
        next_count = count;
        pulse = 1'b0;
        if (hold_clear) begin
            // The prescaler restarts so a new run begins on a clean division.
            next_count = tmc_pkg::PRE_ZERO;
        end else if (tick) begin
            if (count >= last) begin // R4
                next_count = tmc_pkg::PRE_ZERO;
                pulse = 1'b1;
            end else begin
                next_count = count + 3'h1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            count <= tmc_pkg::PRE_ZERO;
        end else begin
            count <= next_count;
        end
    end
endmodule : tmc_prescaler

//--- design/tmc_timer.sv
// Timer clock selection, prescaler, gate control and 16-bit counter with its registers.
// Functional notes
// R1: Clock source 11 picks the cap sense oscillator, 01 the system clock and 00 the system clock divided by four.
// R2: Clock source 10 with the dedicated oscillator off counts rising edges of the external clock pin.
// R3: Clock source 10 with the dedicated oscillator on counts the crystal oscillator on the two crystal pins.
// R4: The prescale field in bits 5-4 divides the selected clock by 8, 4, 2 or 1 for 11, 10, 01 and 00.
// R5: The oscillator enable bit 3 switches the dedicated low-power oscillator on when set and off when clear.
// R6: With source 1X, bit 2 clear synchronises the external clock to the system clock and bit 2 set does not; the code applies bit 2 to source 10 only.
// R7: With source 0X the synchronisation bit is ignored because an internal clock is used.
// R8: Bit 1 of the control register is unimplemented, reads zero and ignores writes.
// R9: The run bit 0 enables counting when set and stops the timer when clear.
// R10: While the run bit is clear the gate toggle flip-flop is cleared.
// R11: All implemented control bits reset to zero on power-on reset and are kept otherwise.
// R12: The gate register holds enable, polarity, toggle and single-pulse bits, a go/done flag, a level and a source.
// R13: Gate source 00 is the gate pin, 01 the other timer overflow, 10 and 11 the two comparator outputs.
// R14: In single-pulse mode the go/done flag clears on the gate trailing edge and blocks counting until set again.
// R15: The counter steps once per prescaler pulse while running and while an enabled gate permits it.
//
// The address-and-strobe port and the address map are this design's own decisions.
`timescale 1ns/1ps
module tmc_timer (
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    input  wire logic [1:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic      [7:0]  reg_rdata,
    input  wire logic        ext_clock_pin,
    input  wire logic        crystal_in_pin,
    output logic             crystal_out_pin,
    output logic             dedicated_osc_enable,
    input  wire logic        cap_sense_oscillator,
    input  wire logic        gate_pin,
    input  wire logic        other_timer_overflow,
    input  wire logic        comp1_sync_out,
    input  wire logic        comp2_sync_out,
    output logic      [15:0] timer_count,
    output logic             timer_overflow
);
    logic [7:0]  control;
    logic [7:0]  next_control;
    logic [7:0]  gate_ctl;
    logic [7:0]  next_gate_ctl;
    logic [7:0]  next_reg_rdata;
    logic        next_osc_enable;
    logic        next_crystal_out;

    // Synchroniser and edge-detect state for the pin-side clocks.
    logic        ext_meta;
    logic        ext_sync;
    logic        ext_sync_prev;
    logic        ext_raw;
    logic        ext_raw_prev;
    logic        cap_prev;
    logic [1:0]  instr_div;
    logic        next_ext_meta;
    logic        next_ext_sync;
    logic        next_ext_sync_prev;
    logic        next_ext_raw;
    logic        next_ext_raw_prev;
    logic        next_cap_prev;
    logic [1:0]  next_instr_div;
    logic        ext_level;
    logic        src_tick;
    logic        pre_pulse;

    // Gate state.
    logic        toggle_ff;
    logic        gate_value;
    logic        next_toggle_ff;
    logic        next_gate_value;
    logic        gate_raw;
    logic        gate_pol;
    logic        gate_pol_prev;
    logic        next_gate_pol_prev;
    logic        gate_toggled;
    logic        gate_level;
    logic        gate_rise;

    // Counter state.
    logic [15:0] next_count;
    logic        next_overflow;
    logic        count_enable;
    logic        prescale_clear;

    logic        wr_control;
    logic        wr_gate;
    logic        wr_lo;
    logic        wr_hi;

    function automatic logic addr_hit(input logic [1:0] addr, input logic [1:0] target);
        addr_hit = (addr == target);
    endfunction : addr_hit

    // A rising edge of a level that is sampled once per system clock.
    function automatic logic rising(input logic level, input logic prev);
        rising = level && !prev;
    endfunction : rising

    assign wr_control = reg_write && addr_hit(reg_addr, tmc_pkg::ADDR_CONTROL);
    assign wr_gate    = reg_write && addr_hit(reg_addr, tmc_pkg::ADDR_GATE);
    assign wr_lo      = reg_write && addr_hit(reg_addr, tmc_pkg::ADDR_COUNT_LO);
    assign wr_hi      = reg_write && addr_hit(reg_addr, tmc_pkg::ADDR_COUNT_HI);

    // Control register: bit 1 has no storage, so it always reads zero.
    always_comb begin
        next_control = control;
        if (wr_control) begin
            next_control = reg_wdata & tmc_pkg::CTL_WMASK; // R8
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            control <= tmc_pkg::CTL_RESET; // R11
        end else begin
            control <= next_control;
        end
    end

    // Gate control register and the go/done flag.
    always_comb begin
        next_gate_ctl = gate_ctl;
        if (wr_gate) begin
            next_gate_ctl = (reg_wdata & tmc_pkg::GT_WMASK) | (gate_ctl & ~tmc_pkg::GT_WMASK); // R12
            next_gate_ctl[tmc_pkg::GT_GO] = reg_wdata[tmc_pkg::GT_GO];
        end
        // A software set of go/done in the same cycle as a trailing edge is kept.
        if (gate_ctl[tmc_pkg::GT_SPM] && gate_value && !next_gate_value
            && !(wr_gate && reg_wdata[tmc_pkg::GT_GO])) begin
            next_gate_ctl[tmc_pkg::GT_GO] = 1'b0; // R14
        end
        next_gate_ctl[tmc_pkg::GT_VAL] = next_gate_value; // R12
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            gate_ctl <= tmc_pkg::GT_RESET; // R11
        end else begin
            gate_ctl <= next_gate_ctl;
        end
    end

    // Oscillator drive, registered so that both pins leave flip-flops.
    always_comb begin
        next_osc_enable = control[tmc_pkg::CTL_OSCEN]; // R5
        // The output stage acts as the inverting amplifier of the crystal loop only while enabled.
        next_crystal_out = control[tmc_pkg::CTL_OSCEN] && !crystal_in_pin; // R5
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            dedicated_osc_enable <= 1'b0;
            crystal_out_pin <= 1'b0;
        end else begin
            dedicated_osc_enable <= next_osc_enable;
            crystal_out_pin <= next_crystal_out;
        end
    end

    // Read port: data stand in the cycle after the read strobe only.
    always_comb begin
        next_reg_rdata = tmc_pkg::DATA_ZERO;
        if (reg_read) begin
            case (reg_addr)
                tmc_pkg::ADDR_CONTROL:  next_reg_rdata = control;
                tmc_pkg::ADDR_GATE:     next_reg_rdata = gate_ctl;
                tmc_pkg::ADDR_COUNT_LO: next_reg_rdata = timer_count[7:0];
                tmc_pkg::ADDR_COUNT_HI: next_reg_rdata = timer_count[15:8];
                default:                next_reg_rdata = tmc_pkg::DATA_ZERO;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= tmc_pkg::DATA_ZERO;
        end else begin
            reg_rdata <= next_reg_rdata;
        end
    end

    // Clock source selection.
    always_comb begin
        ext_level = control[tmc_pkg::CTL_OSCEN] ? crystal_in_pin : ext_clock_pin; // R2 R3
        next_ext_meta = ext_level;
        next_ext_sync = ext_meta;
        next_ext_sync_prev = ext_sync;
        next_ext_raw = ext_level;
        next_ext_raw_prev = ext_raw;
        next_cap_prev = cap_sense_oscillator;
        next_instr_div = instr_div + 2'h1;
        src_tick = 1'b0;
        case (control[tmc_pkg::CTL_CS_HI:tmc_pkg::CTL_CS_LO])
            tmc_pkg::CS_INSTR:  src_tick = (instr_div == tmc_pkg::INSTR_DIV_LAST); // R1 R7
            tmc_pkg::CS_SYSTEM: src_tick = 1'b1; // R1 R7
            tmc_pkg::CS_EXTERNAL: begin
                // The unsynchronised path saves one cycle of latency but may miss short pulses.
                if (control[tmc_pkg::CTL_NOSYNC]) begin
                    src_tick = rising(ext_raw, ext_raw_prev); // R6
                end else begin
                    src_tick = rising(ext_sync, ext_sync_prev); // R6 R2 R3
                end
            end
            tmc_pkg::CS_CAP_OSC: src_tick = rising(cap_sense_oscillator, cap_prev); // R1
            default:             src_tick = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ext_meta <= 1'b0;
            ext_sync <= 1'b0;
            ext_sync_prev <= 1'b0;
            ext_raw <= 1'b0;
            ext_raw_prev <= 1'b0;
            cap_prev <= 1'b0;
            instr_div <= 2'h0;
        end else begin
            ext_meta <= next_ext_meta;
            ext_sync <= next_ext_sync;
            ext_sync_prev <= next_ext_sync_prev;
            ext_raw <= next_ext_raw;
            ext_raw_prev <= next_ext_raw_prev;
            cap_prev <= next_cap_prev;
            instr_div <= next_instr_div;
        end
    end

    // Stopping clears the prescaler so that a restart counts a whole division.
    assign prescale_clear = !control[tmc_pkg::CTL_RUN]; // R9

    tmc_prescaler u_prescaler (
        .sys_clk    (sys_clk),
        .resetn     (resetn),
        .tick       (src_tick),
        .select     (control[tmc_pkg::CTL_PS_HI:tmc_pkg::CTL_PS_LO]),
        .hold_clear (prescale_clear),
        .pulse      (pre_pulse)
    );

    // Gate path: source, polarity, toggle flip-flop, single pulse.
    always_comb begin
        case (gate_ctl[tmc_pkg::GT_SS_HI:tmc_pkg::GT_SS_LO])
            tmc_pkg::GS_PIN:       gate_raw = gate_pin; // R13
            tmc_pkg::GS_OTHER_TMR: gate_raw = other_timer_overflow; // R13
            tmc_pkg::GS_COMP1:     gate_raw = comp1_sync_out; // R13
            tmc_pkg::GS_COMP2:     gate_raw = comp2_sync_out; // R13
            default:               gate_raw = gate_pin;
        endcase
        gate_pol = gate_ctl[tmc_pkg::GT_POL] ? gate_raw : !gate_raw;
        next_gate_pol_prev = gate_pol;
        gate_rise = rising(gate_pol, gate_pol_prev);
        gate_toggled = toggle_ff ^ gate_rise;
        if (!gate_ctl[tmc_pkg::GT_TM] || !control[tmc_pkg::CTL_RUN]) begin
            next_toggle_ff = 1'b0; // R10
        end else begin
            next_toggle_ff = gate_toggled;
        end
        gate_level = gate_ctl[tmc_pkg::GT_TM] ? next_toggle_ff : gate_pol;
        if (gate_ctl[tmc_pkg::GT_SPM]) begin
            next_gate_value = gate_level && gate_ctl[tmc_pkg::GT_GO]; // R14
        end else begin
            next_gate_value = gate_level;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            toggle_ff <= 1'b0;
            gate_pol_prev <= 1'b0;
            gate_value <= 1'b0;
        end else begin
            toggle_ff <= next_toggle_ff;
            gate_pol_prev <= next_gate_pol_prev;
            gate_value <= next_gate_value;
        end
    end

    // Counter: a software write takes precedence over an increment in the same cycle.
    always_comb begin
        count_enable = control[tmc_pkg::CTL_RUN] && (!gate_ctl[tmc_pkg::GT_EN] || gate_value); // R9 R15
        next_count = timer_count;
        next_overflow = 1'b0;
        if (wr_lo) begin
            next_count = {timer_count[15:8], reg_wdata};
        end else if (wr_hi) begin
            next_count = {reg_wdata, timer_count[7:0]};
        end else if (count_enable && pre_pulse) begin
            next_count = timer_count + tmc_pkg::CNT_ONE; // R15
            next_overflow = (timer_count == tmc_pkg::CNT_MAX);
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            timer_count <= tmc_pkg::CNT_ZERO;
            timer_overflow <= 1'b0;
        end else begin
            timer_count <= next_count;
            timer_overflow <= next_overflow;
        end
    end
endmodule : tmc_timer

//--- verification/tmc_timer_properties.sv
// Concurrent checks on the ports of the timer control block.
`timescale 1ns/1ps
module tmc_timer_properties (
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    input  wire logic [1:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    input  wire logic [7:0]  reg_rdata,
    input  wire logic        crystal_out_pin,
    input  wire logic        dedicated_osc_enable,
    input  wire logic [15:0] timer_count,
    input  wire logic        timer_overflow
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    sequence s_ctl_wr;
        reg_write && reg_addr == tmc_pkg::ADDR_CONTROL;
    endsequence
    sequence s_stop_wr;
        s_ctl_wr ##0 !reg_wdata[tmc_pkg::CTL_RUN];
    endsequence

    a_ctl_readback: assert property (
        s_ctl_wr ##1 !reg_write ##1 (reg_read && reg_addr == tmc_pkg::ADDR_CONTROL)
        |=> reg_rdata == ($past(reg_wdata, 3) & tmc_pkg::CTL_WMASK))
        else $error("control readback differs from masked write");
    a_unimpl_bit_zero: assert property (
        $past(reg_read) && $past(reg_addr) == tmc_pkg::ADDR_CONTROL |-> !reg_rdata[1])
        else $error("unimplemented control bit read as one");
    a_osc_follows_write: assert property (
        s_ctl_wr ##1 !reg_write |=> dedicated_osc_enable == $past(reg_wdata[3], 2))
        else $error("oscillator enable does not follow control bit 3");
    a_osc_off_quiet: assert property (
        !dedicated_osc_enable ##1 !dedicated_osc_enable |-> !crystal_out_pin)
        else $error("crystal output driven while oscillator off");
    a_stop_holds_count: assert property (
        s_stop_wr ##1 (!reg_write) [*8] |=> $stable(timer_count))
        else $error("count moved after the run bit was cleared");
    a_count_steps_one: assert property (
        $changed(timer_count) && !$past(reg_write) |-> timer_count == $past(timer_count) + 16'h0001)
        else $error("count changed by other than one");
    a_overflow_cause: assert property (
        $rose(timer_overflow) |-> $past(timer_count) == 16'hffff || $past(timer_count, 2) == 16'hffff)
        else $error("overflow pulse without a wrap");
    a_overflow_single: assert property (timer_overflow |=> !timer_overflow)
        else $error("overflow pulse longer than one cycle");
endmodule : tmc_timer_properties

bind tmc_timer tmc_timer_properties i_tmc_timer_properties (
    .sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .crystal_out_pin(crystal_out_pin), .dedicated_osc_enable(dedicated_osc_enable),
    .timer_count(timer_count), .timer_overflow(timer_overflow)
);

//--- verification/tmc_clock_sources.sv
// Far-side clock sources: external clock pin, crystal and cap sense oscillator.
`timescale 1ns/1ps
module tmc_clock_sources (
    input  wire logic sys_clk,
    input  wire logic resetn,
    input  wire logic osc_enable,
    output logic      ext_clock_pin,
    output logic      crystal_in_pin,
    output logic      cap_sense_oscillator
);
    logic [4:0] phase;

    // Periods of 8, 16 and 32 cycles divide the bench window, so edge counts per window are exact.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            phase <= 5'h00;
        end else begin
            phase <= phase + 5'h01;
        end
    end
    assign ext_clock_pin        = phase[2];
    // A crystal whose amplifier is off does not swing, so its input rests low.
    assign crystal_in_pin       = osc_enable & phase[3];
    assign cap_sense_oscillator = phase[4];
endmodule : tmc_clock_sources

//--- verification/tb_timer_clock_and_gate_control.sv
// Self-checking bench for the timer clock and gate control block.
`timescale 1ns/1ps
module tb_timer_clock_and_gate_control;
    logic        sys_clk;
    logic        resetn;
    logic [1:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_write;
    logic        reg_read;
    logic [7:0]  reg_rdata;
    logic        ext_clock_pin;
    logic        crystal_in_pin;
    logic        crystal_out_pin;
    logic        dedicated_osc_enable;
    logic        cap_sense_oscillator;
    logic [3:0]  gate_src;
    logic [15:0] timer_count;
    logic        timer_overflow;
    logic [7:0]  rd_a;
    logic [7:0]  rd_b;
    int          n_fail;
    int          total_checks;
    int          cycles;
    logic [7:0]  rate_ctl [11] = '{8'h41, 8'h51, 8'h61, 8'h71, 8'h45, 8'h01, 8'h81, 8'h85, 8'h89, 8'hc1, 8'h40};
    logic [7:0]  rate_exp [11] = '{8'h40, 8'h20, 8'h10, 8'h08, 8'h40, 8'h10, 8'h08, 8'h08, 8'h04, 8'h02, 8'h00};

    tmc_timer i_tmc_timer (
        .sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .ext_clock_pin(ext_clock_pin), .crystal_in_pin(crystal_in_pin), .crystal_out_pin(crystal_out_pin),
        .dedicated_osc_enable(dedicated_osc_enable), .cap_sense_oscillator(cap_sense_oscillator),
        .gate_pin(gate_src[0]), .other_timer_overflow(gate_src[1]), .comp1_sync_out(gate_src[2]),
        .comp2_sync_out(gate_src[3]), .timer_count(timer_count), .timer_overflow(timer_overflow)
    );
    tmc_clock_sources i_tmc_clock_sources (
        .sys_clk(sys_clk), .resetn(resetn), .osc_enable(dedicated_osc_enable), .ext_clock_pin(ext_clock_pin),
        .crystal_in_pin(crystal_in_pin), .cap_sense_oscillator(cap_sense_oscillator)
    );

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    task automatic end_sim();
        if (n_fail == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_sim

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_fail++;
            end_sim();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge sys_clk);
        reg_write <= 1'b0;
    endtask : wr

    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge sys_clk);
        reg_read <= 1'b0;
        @(negedge sys_clk);
        d = reg_rdata;
    endtask : rd

    task automatic rd_check(input logic [1:0] a, input logic [7:0] exp, input string what);
        logic [7:0] v;
        rd(a, v);
        check(v, exp, what);
    endtask : rd_check

    // Two reads 64 cycles apart; the difference is independent of prescaler phase.
    task automatic rate(input logic [7:0] ctl, input logic [7:0] exp);
        logic xin;
        wr(tmc_pkg::ADDR_CONTROL, ctl);
        repeat (16) @(posedge sys_clk);
        rd(tmc_pkg::ADDR_COUNT_LO, rd_a);
        check({7'h00, dedicated_osc_enable}, {7'h00, ctl[3]}, "osc enable");
        xin = crystal_in_pin;
        @(negedge sys_clk);
        check({7'h00, crystal_out_pin}, {7'h00, ctl[3] & ~xin}, "crystal drive");
        repeat (61) @(posedge sys_clk);
        rd(tmc_pkg::ADDR_COUNT_LO, rd_b);
        check(rd_b - rd_a, exp, "count step");
    endtask : rate

    initial begin
        resetn = 1'b0;
        reg_addr = 2'h0;
        reg_wdata = 8'h00;
        reg_write = 1'b0;
        reg_read = 1'b0;
        gate_src = 4'hf;
        n_fail = 0;
        total_checks = 0;
        cycles = 0;
        repeat (16) @(posedge sys_clk);
        resetn <= 1'b1;
        for (int i = 0; i < 4; i++) rd_check(2'(i), 8'h00, "reset value");
        wr(tmc_pkg::ADDR_CONTROL, 8'hfe);
        rd_check(tmc_pkg::ADDR_CONTROL, 8'hfc, "control bit 1");
        for (int s = 0; s < 4; s++) begin
            wr(tmc_pkg::ADDR_GATE, 8'h44 | 8'(s));
            gate_src <= 4'h1 << s;
            rd_check(tmc_pkg::ADDR_GATE, 8'h44 | 8'(s), "gate source high");
            @(posedge sys_clk);
            gate_src <= ~(4'h1 << s);
            rd_check(tmc_pkg::ADDR_GATE, 8'h40 | 8'(s), "gate source low");
        end
        wr(tmc_pkg::ADDR_GATE, 8'h00);
        for (int i = 0; i < 11; i++) rate(rate_ctl[i], rate_exp[i]);
        @(posedge sys_clk);
        gate_src <= 4'h0;
        // The toggle flip-flop is held clear while stopped, so the timer must run first.
        wr(tmc_pkg::ADDR_CONTROL, 8'h41);
        wr(tmc_pkg::ADDR_GATE, 8'he0);
        @(posedge sys_clk);
        gate_src <= 4'h1;
        repeat (2) @(posedge sys_clk);
        gate_src <= 4'h0;
        rd_check(tmc_pkg::ADDR_GATE, 8'he4, "toggle set");
        wr(tmc_pkg::ADDR_CONTROL, 8'h40);
        wr(tmc_pkg::ADDR_CONTROL, 8'h41);
        rd_check(tmc_pkg::ADDR_GATE, 8'he0, "toggle cleared");
        rate(8'h41, 8'h00);
        wr(tmc_pkg::ADDR_GATE, 8'hd8);
        gate_src <= 4'h1;
        repeat (10) @(posedge sys_clk);
        gate_src <= 4'h0;
        repeat (3) @(posedge sys_clk);
        rd_check(tmc_pkg::ADDR_GATE, 8'hd0, "go cleared");
        @(posedge sys_clk);
        gate_src <= 4'h1;
        rate(8'h41, 8'h00);
        wr(tmc_pkg::ADDR_CONTROL, 8'h40);
        wr(tmc_pkg::ADDR_GATE, 8'h00);
        wr(tmc_pkg::ADDR_COUNT_LO, 8'hfe);
        wr(tmc_pkg::ADDR_COUNT_HI, 8'hff);
        rd_check(tmc_pkg::ADDR_COUNT_HI, 8'hff, "count high");
        wr(tmc_pkg::ADDR_CONTROL, 8'h41);
        rd_b = 8'h00;
        repeat (8) begin
            @(negedge sys_clk);
            if (timer_overflow === 1'b1) rd_b = 8'h01;
        end
        check(rd_b, 8'h01, "overflow");
        end_sim();
    end
endmodule : tb_timer_clock_and_gate_control
